// ==== design/sacc_defs.vh ====
`ifndef SACC_DEFS_VH
`define SACC_DEFS_VH

// result word width and code space
`define SACC_RES_W        14
`define SACC_NUM_CODES    16384
`define SACC_MSB_IDX      13
// internal conversion clock: one bit step every DIV cycles of mclk
`define SACC_CLK_NS       10
`define SACC_STEP_NS      130
`define SACC_STEP_DIV     ((`SACC_STEP_NS + `SACC_CLK_NS - 1) / `SACC_CLK_NS)
`define SACC_DIV_W        8
// host-side figures, kept for reference only; neither design nor bench uses them
`define SACC_ACQ_MIN_NS   400
`define SACC_WAKE_NS      400
`define SACC_EARLY_NS     900
// power states
`define SACC_PWR_ON       2'b00
`define SACC_PWR_NAP      2'b01
`define SACC_PWR_SLEEP    2'b10

`endif

// ==== design/sacc_step_div.v ====
`timescale 1ns/1ps
`default_nettype none
`include "sacc_defs.vh"

// divider making the internal bit-step enable, held cleared while run_in is low
module sacc_step_div (
	input  wire mclk_in,
	input  wire rstn_in,
	input  wire run_in,
	output reg  step_out
);
	reg [`SACC_DIV_W-1:0] cnt_q;

	always @(posedge mclk_in) begin
		if (!rstn_in || !run_in) begin
			cnt_q    <= {`SACC_DIV_W{1'b0}};
			step_out <= 1'b0;
		end else if (cnt_q == `SACC_STEP_DIV - 1) begin
			cnt_q    <= {`SACC_DIV_W{1'b0}};
			step_out <= 1'b1;
		end else begin
			cnt_q    <= cnt_q + 8'h01;
			step_out <= 1'b0;
		end
	end
endmodule // sacc_step_div

`default_nettype wire

// ==== design/sacc_conv_ctrl.v ====
`timescale 1ns/1ps
`default_nettype none
`include "sacc_defs.vh"

module sacc_conv_ctrl (
	input  wire                     mclk_in,
	input  wire                     rstn_in,
	input  wire                     chip_select_n_in,
	input  wire                     read_n_in,
	input  wire                     convert_start_n_in,
	input  wire                     power_down_n_in,
	input  wire                     comp_in,
	output reg                      busy_n_out,
	output reg  [`SACC_RES_W-1:0]   result_bus_out,
	output reg  [`SACC_RES_W-1:0]   result_bus_oe_out,
	output reg  [`SACC_RES_W-1:0]   dac_code_out,
	output reg                      sample_out,
	output reg  [1:0]               power_state_out
);
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_CONV = 3'b010;
	localparam [2:0] ST_DONE = 3'b100;

	// two-flop synchronisers on every pin except rstn_in
	reg [1:0] cs_s_q;
	reg [1:0] rd_s_q;
	reg [1:0] cv_s_q;
	reg [1:0] pd_s_q;
	reg [1:0] cp_s_q;
	reg       cv_prev_q;
	reg       pd_prev_q;
	reg [2:0] state_q;
	reg [`SACC_RES_W-1:0] approx_q;
	reg [`SACC_RES_W-1:0] trial_q;
	reg [`SACC_RES_W-1:0] latch_q;
	wire cs_n  = cs_s_q[1];
	wire rd_n  = rd_s_q[1];
	wire cv_n  = cv_s_q[1];
	wire pd_n  = pd_s_q[1];
	wire comp  = cp_s_q[1];
	wire start = cv_prev_q & ~cv_n & ~cs_n & pd_n;
	wire step;

	// conversion steps paced internally, no host clock
	sacc_step_div u_div (
		.mclk_in  (mclk_in),
		.rstn_in  (rstn_in),
		.run_in   (state_q == ST_CONV),
		.step_out (step)
	);

	always @(posedge mclk_in) begin
		if (!rstn_in) begin
			cs_s_q    <= 2'h3;
			rd_s_q    <= 2'h3;
			cv_s_q    <= 2'h3;
			pd_s_q    <= 2'h3;
			cp_s_q    <= 2'h0;
			cv_prev_q <= 1'b1;
			pd_prev_q <= 1'b1;
		end else begin
			cs_s_q    <= {cs_s_q[0], chip_select_n_in};
			rd_s_q    <= {rd_s_q[0], read_n_in};
			cv_s_q    <= {cv_s_q[0], convert_start_n_in};
			pd_s_q    <= {pd_s_q[0], power_down_n_in};
			cp_s_q    <= {cp_s_q[0], comp_in};
			cv_prev_q <= cv_n;
			pd_prev_q <= pd_n;
		end
	end

	// power mode picked by chip select at the falling power_down_n edge
	always @(posedge mclk_in) begin
		if (!rstn_in)
			power_state_out <= `SACC_PWR_ON;
		else if (pd_n)
			power_state_out <= `SACC_PWR_ON;
		else if (pd_prev_q) begin
			if (!cs_n)
				power_state_out <= `SACC_PWR_NAP;
			else
				power_state_out <= `SACC_PWR_SLEEP;
		end
	end

	// sequencer; start edges outside idle are dropped
	always @(posedge mclk_in) begin
		if (!rstn_in) begin
			state_q      <= ST_IDLE;
			approx_q     <= {`SACC_RES_W{1'b0}};
			trial_q      <= {`SACC_RES_W{1'b0}};
			latch_q      <= {`SACC_RES_W{1'b0}};
			busy_n_out   <= 1'b1;
			dac_code_out <= {`SACC_RES_W{1'b0}};
			sample_out   <= 1'b1;
		end else begin
			case (state_q)
			ST_IDLE: begin
				if (start) begin
					state_q    <= ST_CONV;
					approx_q   <= {`SACC_RES_W{1'b0}};
					trial_q    <= {1'b1, {(`SACC_RES_W-1){1'b0}}};
					busy_n_out <= 1'b0;
					sample_out <= 1'b0;
					// offset binary trial, msb set
					dac_code_out <= {1'b1, {(`SACC_RES_W-1){1'b0}}};
				end
			end
			ST_CONV: begin
				if (step) begin
					// keep trial bit when comparator says input is above
					if (comp)
						approx_q <= approx_q | trial_q;
					trial_q <= trial_q >> 1;
					dac_code_out <= (comp ? (approx_q | trial_q) : approx_q)
						| (trial_q >> 1);
					if (trial_q[0])
						state_q <= ST_DONE;
				end
			end
			ST_DONE: begin
				// offset binary to two's complement: flip msb
				latch_q <= approx_q ^ {1'b1, {(`SACC_RES_W-1){1'b0}}};
				state_q <= ST_IDLE;
				sample_out <= 1'b1;
			end
			default: state_q <= ST_IDLE;
			endcase
			// busy rises one cycle after the latch load
			if (state_q == ST_DONE)
				busy_n_out <= 1'b0;
			else if (state_q == ST_IDLE && !start)
				busy_n_out <= 1'b1;
		end
	end

	// three-state port: data and enable registered
	always @(posedge mclk_in) begin
		if (!rstn_in) begin
			result_bus_out    <= {`SACC_RES_W{1'b0}};
			result_bus_oe_out <= {`SACC_RES_W{1'b0}};
		end else begin
			result_bus_out    <= latch_q;
			result_bus_oe_out <= {`SACC_RES_W{~cs_n & ~rd_n}};
		end
	end
endmodule // sacc_conv_ctrl

`default_nettype wire

// ==== bench/sacc_chk_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module sacc_chk (
	input wire logic        mclk_in, rstn_in, chip_select_n_in, read_n_in,
	input wire logic        convert_start_n_in, power_down_n_in, comp_in,
	input wire logic        busy_n_out, sample_out,
	input wire logic [13:0] result_bus_out, result_bus_oe_out, dac_code_out,
	input wire logic [1:0]  power_state_out
);
default clocking @(posedge mclk_in); endclocking
default disable iff (!rstn_in);
property p_oe; |result_bus_oe_out |->
	$past(!read_n_in && !chip_select_n_in, 3); endproperty
property p_eq; result_bus_oe_out == 0 || &result_bus_oe_out; endproperty
property p_go; $fell(busy_n_out) |-> !sample_out &&
	dac_code_out == 14'h2000 && $past(!chip_select_n_in, 3); endproperty
property p_len; $fell(busy_n_out) |->
	##170 !busy_n_out ##[1:40] busy_n_out; endproperty
property p_hold; !busy_n_out |-> $stable(result_bus_out); endproperty
property p_st; $fell(convert_start_n_in) && !chip_select_n_in &&
	power_down_n_in && power_state_out == 2'b00 && busy_n_out
	|-> ##[2:6] !busy_n_out; endproperty
property p_pd; $fell(power_down_n_in) |-> ##[2:6]
	power_state_out == (chip_select_n_in ? 2'b10 : 2'b01); endproperty
property p_msb; $fell(busy_n_out) |-> ##[10:16] dac_code_out[12]; endproperty
a_oe: assert property (p_oe) else $error("oe bad");
a_eq: assert property (p_eq) else $error("oe split");
a_go: assert property (p_go) else $error("start bad");
a_len: assert property (p_len) else $error("busy len");
a_hold: assert property (p_hold) else $error("latch moved");
a_st: assert property (p_st) else $error("no start");
a_pd: assert property (p_pd) else $error("power mode");
a_msb: assert property (p_msb) else $error("bit order");
c_conv: cover property ($rose(busy_n_out));
c_rd: cover property (|result_bus_oe_out);
c_nap: cover property (power_state_out == 2'b01);
endmodule // sacc_chk
`default_nettype wire

// ==== bench/sacc_cmp_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// comparator; analog input level given as offset binary code
module sacc_cmp_model (
	input wire logic [13:0] dac_in, lvl_in,
	output logic            comp_out
);
assign comp_out = lvl_in >= dac_in;
endmodule // sacc_cmp_model
`default_nettype wire

// ==== bench/sar_adc_conversion_control_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module sar_adc_conversion_control_tb;
logic mclk_in = 0, rstn_in = 0, cs_n = 1, rd_n = 1, cv_n = 1, pd_n = 1;
logic busy_n, smp, comp;
logic [13:0] rb, oe, dac, lvl = 0;
logic [1:0] ps;
int err_count = 0, check_count = 0;
initial forever #5 mclk_in = ~mclk_in;
sacc_conv_ctrl DUT (.mclk_in(mclk_in), .rstn_in(rstn_in),
	.chip_select_n_in(cs_n), .read_n_in(rd_n), .convert_start_n_in(cv_n),
	.power_down_n_in(pd_n), .comp_in(comp), .busy_n_out(busy_n),
	.result_bus_out(rb), .result_bus_oe_out(oe), .dac_code_out(dac),
	.sample_out(smp), .power_state_out(ps));
sacc_cmp_model CMP (.dac_in(dac), .lvl_in(lvl), .comp_out(comp));
task tick(int n); repeat (n) @(posedge mclk_in); endtask
task chk(logic [13:0] g, e);
	check_count++;
	if (g !== e) begin
		err_count++;
		$display("[ERR] %0t got %h exp %h", $time, g, e);
	end
endtask
task wrap_up;
	$display("checks %0d errors %0d", check_count, err_count);
	if (err_count == 0 && check_count > 0) $display("STATUS OK");
	else $display("STATUS NOT OK");
	$finish;
endtask
task conv(logic [13:0] t);
	int n;
	lvl <= t;
	cv_n <= 0;
	tick(4);
	cv_n <= 1;
	tick(2);
	chk(14'(busy_n), 0);
	tick(50);
	cv_n <= 0;
	tick(5);
	cv_n <= 1;
	for (n = 0; n < 300 && busy_n !== 1; n++) tick(1);
	chk(14'(n < 300), 1);
	chk(14'(n < 140), 1);
	chk(rb, t ^ 14'h2000);
	rd_n <= 0;
	tick(5);
	chk(oe, 14'h3fff);
	rd_n <= 1;
	tick(45);
endtask
task refuse;
	cs_n <= 1;
	rd_n <= 0;
	tick(4);
	cv_n <= 0;
	tick(4);
	cv_n <= 1;
	tick(6);
	chk(14'(busy_n), 1);
	chk(oe, 0);
	rd_n <= 1;
endtask
task pwr(logic c, logic [1:0] e);
	cs_n <= c;
	tick(4);
	pd_n <= 0;
	tick(6);
	chk(14'(ps), 14'(e));
	cv_n <= 0;
	tick(4);
	cv_n <= 1;
	tick(6);
	chk(14'(busy_n), 1);
	pd_n <= 1;
	tick(45);
	chk(14'(ps), 0);
	cs_n <= 0;
	tick(4);
endtask
initial begin
	tick(3);
	rstn_in <= 1;
	cs_n <= 0;
	tick(5);
	chk(oe, 0);
	conv(14'h0000);
	conv(14'h3fff);
	conv(14'h2000);
	conv(14'h1555);
	refuse;
	pwr(1, 2'b10);
	pwr(0, 2'b01);
	conv(14'h2aaa);
	wrap_up;
end
initial begin
	#60us;
	err_count++;
	wrap_up;
end
endmodule // sar_adc_conversion_control_tb
bind sacc_conv_ctrl sacc_chk CHK (.mclk_in, .rstn_in, .chip_select_n_in,
	.read_n_in, .convert_start_n_in, .power_down_n_in, .comp_in,
	.busy_n_out, .sample_out, .result_bus_out, .result_bus_oe_out,
	.dac_code_out, .power_state_out);
`default_nettype wire
